/* design/dfc_channel.sv */
`timescale 1ns/1ns
module dfc_channel (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_wr_ctrl,
  input  wire logic              i_wr_high,
  input  wire logic              i_wr_low,
  input  wire logic [7:0]        i_wdata,
  input  wire logic [3:0]        i_ovf_by_mode,
  output dfc_pkg::dfc_ctrl_t     o_ctrl,
  output logic [7:0]             o_high,
  output logic [7:0]             o_low,
  output dfc_pkg::dfc_out_t      o_out
);

  dfc_pkg::dfc_ctrl_t ctrl_q;
  logic [7:0]         high_q;
  logic [7:0]         low_q;
  logic [11:0]        code_q;
  logic               drive_q;

  // control register, unused bits forced to zero
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= dfc_pkg::DFC_CTRL_RST;
    end else if (i_wr_ctrl) begin
      ctrl_q <= i_wdata & dfc_pkg::DFC_CTRL_WMASK;
    end
  end

  // held data bytes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      high_q <= dfc_pkg::DFC_DATA_RST;
      low_q  <= dfc_pkg::DFC_DATA_RST;
    end else begin
      if (i_wr_high) begin
        high_q <= i_wdata;
      end
      if (i_wr_low) begin
        low_q <= i_wdata;
      end
    end
  end

  // converter input latch
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      code_q <= dfc_pkg::DFC_CODE_RST;
    end else if (ctrl_q.dac_update_mode == dfc_pkg::DFC_MODE_DEMAND) begin
      if (i_wr_high) begin
        code_q <= dfc_pkg::dfc_pack_code(ctrl_q.dac_word_format, i_wdata, low_q);
      end
    end else if (i_ovf_by_mode[ctrl_q.dac_update_mode]) begin
      code_q <= dfc_pkg::dfc_pack_code(ctrl_q.dac_word_format, high_q, low_q);
    end
  end

  // output drive follows enable
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= ctrl_q.dac_channel_enable;
    end
  end

  assign o_ctrl       = ctrl_q;
  assign o_high       = high_q;
  assign o_low        = low_q;
  assign o_out.code     = code_q;
  assign o_out.drive_en = drive_q;

endmodule : dfc_channel

/* design/dfc_pkg.sv */
package dfc_pkg;

  // register selector codes on the register port
  localparam logic [1:0] DFC_SEL_CTRL  = 2'h0;
  localparam logic [1:0] DFC_SEL_HIGH  = 2'h1;
  localparam logic [1:0] DFC_SEL_LOW   = 2'h2;

  // channel count and widths
  localparam int         DFC_NUM_CHAN  = 2;
  localparam int         DFC_CODE_W    = 12;

  // reset values
  localparam logic [7:0] DFC_CTRL_RST  = 8'h00;
  localparam logic [7:0] DFC_DATA_RST  = 8'h00;
  localparam logic [11:0] DFC_CODE_RST = 12'h000;

  // writable control bits: enable, mode, format
  localparam logic [7:0] DFC_CTRL_WMASK = 8'h9F;

  // update mode encodings
  localparam logic [1:0] DFC_MODE_DEMAND = 2'h0;
  localparam logic [1:0] DFC_MODE_TMR3   = 2'h1;
  localparam logic [1:0] DFC_MODE_TMR4   = 2'h2;
  localparam logic [1:0] DFC_MODE_TMR2   = 2'h3;

  // control register layout
  typedef struct packed {
    logic       dac_channel_enable;
    logic [1:0] unused;
    logic [1:0] dac_update_mode;
    logic [2:0] dac_word_format;
  } dfc_ctrl_t;

  // channel output toward the analog stage
  typedef struct packed {
    logic [11:0] code;
    logic        drive_en;
  } dfc_out_t;

  // pack high and low bytes into the converter code
  function automatic logic [11:0] dfc_pack_code(input logic [2:0] fmt,
                                                input logic [7:0] hi,
                                                input logic [7:0] lo);
    logic [11:0] c;
    c = {hi[3:0], lo[7:0]};
    if (fmt[2]) begin
      c = {hi[7:0], lo[7:4]};
    end else begin
      unique case (fmt[1:0])
        2'h0: c = {hi[3:0], lo[7:0]};
        2'h1: c = {hi[4:0], lo[7:1]};
        2'h2: c = {hi[5:0], lo[7:2]};
        2'h3: c = {hi[6:0], lo[7:3]};
      endcase
    end
    return c;
  endfunction : dfc_pack_code

endpackage : dfc_pkg

/* design/dfc_top.sv */
`timescale 1ns/1ns
module dfc_top (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_wr_en,
  input  wire logic                     i_rd_en,
  input  wire logic                     i_chan_sel,
  input  wire logic [1:0]               i_reg_sel,
  input  wire logic [7:0]               i_wdata,
  input  wire logic                     i_tmr3_ovf,
  input  wire logic                     i_tmr4_ovf,
  input  wire logic                     i_tmr2_ovf,
  output logic [7:0]                    o_rdata,
  output logic                          o_rd_valid,
  output dfc_pkg::dfc_out_t [1:0]       o_chan_out
);

  logic                     rst_meta_q;
  logic                     rst_sync_q;
  logic [3:0]               ovf_by_mode;
  logic [1:0]               wr_ctrl;
  logic [1:0]               wr_high;
  logic [1:0]               wr_low;
  dfc_pkg::dfc_ctrl_t [1:0] ctrl_w;
  logic [7:0]               high_w [2];
  logic [7:0]               low_w  [2];
  dfc_pkg::dfc_out_t [1:0]  out_w;
  logic [7:0]               rdata_q;
  logic                     rd_valid_q;
  logic [7:0]               rdata_d;

  // reset release through two flops
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // overflow pulse indexed by update mode
  assign ovf_by_mode = {i_tmr2_ovf, i_tmr4_ovf, i_tmr3_ovf, 1'b0};

  // per-channel write decode and instances
  generate
    for (genvar c = 0; c < dfc_pkg::DFC_NUM_CHAN; c++) begin : g_chan
      assign wr_ctrl[c] = i_wr_en && (i_chan_sel == 1'(c)) && (i_reg_sel == dfc_pkg::DFC_SEL_CTRL);
      assign wr_high[c] = i_wr_en && (i_chan_sel == 1'(c)) && (i_reg_sel == dfc_pkg::DFC_SEL_HIGH);
      assign wr_low[c]  = i_wr_en && (i_chan_sel == 1'(c)) && (i_reg_sel == dfc_pkg::DFC_SEL_LOW);

      dfc_channel u_chan (
        .i_sys_clk     (i_sys_clk),
        .i_rst_n       (rst_sync_q),
        .i_wr_ctrl     (wr_ctrl[c]),
        .i_wr_high     (wr_high[c]),
        .i_wr_low      (wr_low[c]),
        .i_wdata       (i_wdata),
        .i_ovf_by_mode (ovf_by_mode),
        .o_ctrl        (ctrl_w[c]),
        .o_high        (high_w[c]),
        .o_low         (low_w[c]),
        .o_out         (out_w[c])
      );
    end
  endgenerate

  // read multiplexer, unmapped selector reads zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (i_reg_sel)
      dfc_pkg::DFC_SEL_CTRL: rdata_d = ctrl_w[i_chan_sel];
      dfc_pkg::DFC_SEL_HIGH: rdata_d = high_w[i_chan_sel];
      dfc_pkg::DFC_SEL_LOW:  rdata_d = low_w[i_chan_sel];
      default:               rdata_d = 8'h00;
    endcase
  end

  // registered read answer
  always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q    <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= i_rd_en;
      if (i_rd_en) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign o_rdata    = rdata_q;
  assign o_rd_valid = rd_valid_q;
  assign o_chan_out = out_w;

  // format 000 on demand update
  AST_FMT_000: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (wr_high[0] && ctrl_w[0].dac_update_mode == 2'h0 && ctrl_w[0].dac_word_format == 3'h0)
    |=> out_w[0].code == {$past(i_wdata[3:0], 1), low_w[0]})
    else $error("format 000 code wrong");

  // format 001 on demand update
  AST_FMT_001: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (wr_high[0] && ctrl_w[0].dac_update_mode == 2'h0 && ctrl_w[0].dac_word_format == 3'h1)
    |=> out_w[0].code == {$past(i_wdata[4:0], 1), low_w[0][7:1]})
    else $error("format 001 code wrong");

  // format 010 on demand update
  AST_FMT_010: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (wr_high[0] && ctrl_w[0].dac_update_mode == 2'h0 && ctrl_w[0].dac_word_format == 3'h2)
    |=> out_w[0].code == {$past(i_wdata[5:0], 1), low_w[0][7:2]})
    else $error("format 010 code wrong");

  // format 011 on demand update
  AST_FMT_011: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (wr_high[0] && ctrl_w[0].dac_update_mode == 2'h0 && ctrl_w[0].dac_word_format == 3'h3)
    |=> out_w[0].code == {$past(i_wdata[6:0], 1), low_w[0][7:3]})
    else $error("format 011 code wrong");

  // format 1xx on demand update
  AST_FMT_1XX: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (wr_high[0] && ctrl_w[0].dac_update_mode == 2'h0 && ctrl_w[0].dac_word_format[2])
    |=> out_w[0].code == {$past(i_wdata, 1), low_w[0][7:4]})
    else $error("format 1xx code wrong");

  // unused control bits read back zero
  AST_UNUSED_ZERO: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (i_rd_en && i_reg_sel == 2'h0) |=> o_rd_valid && o_rdata[6:5] == 2'b00)
    else $error("unused control bits not zero");

  // timer 4 overflow copies held bytes in mode 10
  AST_TMR4_COPY: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (ctrl_w[1].dac_update_mode == 2'h2 && i_tmr4_ovf && !wr_ctrl[1])
    |=> out_w[1].code == dfc_pkg::dfc_pack_code($past(ctrl_w[1].dac_word_format, 1),
                                                $past(high_w[1], 1), $past(low_w[1], 1)))
    else $error("timer 4 overflow did not update code");

  // timer modes hold code without their overflow
  AST_TMR_HOLD: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (ctrl_w[1].dac_update_mode != 2'h0 && !ovf_by_mode[ctrl_w[1].dac_update_mode])
    |=> $stable(out_w[1].code))
    else $error("code changed without overflow");

  // low byte write alone leaves code unchanged
  AST_LOW_HELD: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (wr_low[0] && ctrl_w[0].dac_update_mode == 2'h0) |=> $stable(out_w[0].code))
    else $error("low write changed code");

  // second channel writes leave first channel alone
  AST_CHAN_ISOLATE: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (i_wr_en && i_chan_sel) |=> ($stable(ctrl_w[0]) && $stable(high_w[0]) && $stable(low_w[0])))
    else $error("channel 1 write disturbed channel 0");

  // drive enable tracks enable bit one cycle later
  AST_DRIVE_EN: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    $changed(ctrl_w[1].dac_channel_enable) |=> out_w[1].drive_en == $past(ctrl_w[1].dac_channel_enable, 1))
    else $error("drive enable does not follow enable bit");

  // second channel format 1xx on demand update
  AST_FMT_1XX_CH1: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (wr_high[1] && ctrl_w[1].dac_update_mode == 2'h0 && ctrl_w[1].dac_word_format[2])
    |=> out_w[1].code == {$past(i_wdata, 1), low_w[1][7:4]})
    else $error("second channel format 1xx code wrong");

  // timer 3 overflow copies held bytes in mode 01
  AST_TMR3_COPY: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (ctrl_w[1].dac_update_mode == 2'h1 && ctrl_w[1].dac_word_format[2] && i_tmr3_ovf)
    |=> out_w[1].code == {$past(high_w[1], 1), $past(low_w[1][7:4], 1)})
    else $error("timer 3 overflow did not update code");

  // timer 2 overflow copies held bytes in mode 11
  AST_TMR2_COPY: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (ctrl_w[1].dac_update_mode == 2'h3 && ctrl_w[1].dac_word_format[2] && i_tmr2_ovf)
    |=> out_w[1].code == {$past(high_w[1], 1), $past(low_w[1][7:4], 1)})
    else $error("timer 2 overflow did not update code");

  // on-demand mode changes code only on a high write
  AST_DEMAND_HOLD: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (ctrl_w[0].dac_update_mode == 2'h0 && !wr_high[0]) |=> $stable(out_w[0].code))
    else $error("code changed without high write");

  // second channel on-demand hold
  AST_DEMAND_HOLD_CH1: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (ctrl_w[1].dac_update_mode == 2'h0 && !wr_high[1]) |=> $stable(out_w[1].code))
    else $error("second channel code changed without high write");

  // control write keeps enable, mode and format, drops bits 6:5
  AST_CTRL_WR_CH0: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    wr_ctrl[0] |=> (ctrl_w[0].dac_channel_enable == $past(i_wdata[7], 1) && ctrl_w[0].unused == 2'h0 &&
                    ctrl_w[0].dac_update_mode == $past(i_wdata[4:3], 1) &&
                    ctrl_w[0].dac_word_format == $past(i_wdata[2:0], 1)))
    else $error("control write stored wrong value");

  // second channel control write
  AST_CTRL_WR_CH1: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    wr_ctrl[1] |=> (ctrl_w[1].dac_channel_enable == $past(i_wdata[7], 1) && ctrl_w[1].unused == 2'h0 &&
                    ctrl_w[1].dac_update_mode == $past(i_wdata[4:3], 1) &&
                    ctrl_w[1].dac_word_format == $past(i_wdata[2:0], 1)))
    else $error("second channel control write stored wrong value");

  // first channel writes leave second channel alone
  AST_CHAN_ISOLATE_CH1: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    (i_wr_en && !i_chan_sel) |=> ($stable(ctrl_w[1]) && $stable(high_w[1]) && $stable(low_w[1])))
    else $error("channel 0 write disturbed channel 1");

  // first channel drive enable follows enable bit
  AST_DRIVE_EN_CH0: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
    $changed(ctrl_w[0].dac_channel_enable) |=> out_w[0].drive_en == $past(ctrl_w[0].dac_channel_enable, 1))
    else $error("first channel drive enable does not follow enable bit");

  // both codes zero and second channel drive off right after reset release
  AST_RESET_IDLE: assert property (@(posedge i_sys_clk)
    $rose(rst_sync_q) |-> (!out_w[1].drive_en && out_w[0].code == 12'h000 && out_w[1].code == 12'h000))
    else $error("channel not idle after reset");

  // control clear after reset release
  AST_RESET_CLEAR: assert property (@(posedge i_sys_clk)
    $rose(rst_sync_q) |-> (ctrl_w[0] == 8'h00 && ctrl_w[1] == 8'h00 && !out_w[0].drive_en))
    else $error("control not cleared by reset");

endmodule : dfc_top

/* dv/dfc_top_tb.sv */
`timescale 1ns/1ns
module dfc_top_tb;
  // one table row: channel, format, bytes and the code they should give
  typedef struct packed {
    logic        ch;
    logic [2:0]  fmt;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [11:0] code;
  } dfc_row_t;

  logic                          i_sys_clk, i_rst_n, i_wr_en, i_rd_en, i_chan_sel;
  logic [1:0]                    i_reg_sel;
  logic [7:0]                    i_wdata;
  logic                          i_tmr3_ovf, i_tmr4_ovf, i_tmr2_ovf;
  logic [7:0]                    o_rdata;
  logic                          o_rd_valid;
  dfc_pkg::dfc_out_t [1:0]       o_chan_out;
  int                            errors, n_tests;
  logic [11:0]                   prev [2];
  dfc_row_t                      rows [8];

  dfc_top DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
               .i_chan_sel(i_chan_sel), .i_reg_sel(i_reg_sel), .i_wdata(i_wdata),
               .i_tmr3_ovf(i_tmr3_ovf), .i_tmr4_ovf(i_tmr4_ovf), .i_tmr2_ovf(i_tmr2_ovf),
               .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_chan_out(o_chan_out));

  // free-running system clock
  always #25 i_sys_clk = ~i_sys_clk;

  // compare and count
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one register write, returns at the edge that takes it
  task automatic wr(input logic ch, input logic [1:0] sel, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr_en    <= 1'h1;
    i_chan_sel <= ch;
    i_reg_sel  <= sel;
    i_wdata    <= d;
    @(posedge i_sys_clk);
    i_wr_en    <= 1'h0;
  endtask : wr

  // one register read, checks valid strobe and data together
  task automatic rd(input logic ch, input logic [1:0] sel, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_rd_en    <= 1'h1;
    i_chan_sel <= ch;
    i_reg_sel  <= sel;
    @(posedge i_sys_clk);
    i_rd_en    <= 1'h0;
    #1;
    chk({3'h0, o_rd_valid, o_rdata}, {4'h1, exp});
  endtask : rd

  // one-cycle overflow pulses, bit 0 timer 3, bit 1 timer 4, bit 2 timer 2
  task automatic pulse(input logic [2:0] t);
    @(posedge i_sys_clk);
    {i_tmr2_ovf, i_tmr4_ovf, i_tmr3_ovf} <= t;
    @(posedge i_sys_clk);
    {i_tmr2_ovf, i_tmr4_ovf, i_tmr3_ovf} <= 3'h0;
  endtask : pulse

  // let one more edge land
  task automatic step();
    @(posedge i_sys_clk);
    #1;
  endtask : step

  // verdict and end of run
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    errors++;
    $display("watchdog expired");
    conclude();
  end

  // main sequence
  initial begin
    rows = '{'{1'h0, 3'h0, 8'hA5, 8'h3C, 12'h53C}, '{1'h0, 3'h1, 8'hF3, 8'h81, 12'h9C0},
             '{1'h0, 3'h2, 8'hC9, 8'hFC, 12'h27F}, '{1'h0, 3'h3, 8'h55, 8'hA8, 12'hAB5},
             '{1'h1, 3'h4, 8'h12, 8'h3F, 12'h123}, '{1'h1, 3'h5, 8'hFE, 8'hDC, 12'hFED},
             '{1'h1, 3'h6, 8'h80, 8'h1F, 12'h801}, '{1'h0, 3'h7, 8'h7B, 8'hE0, 12'h7BE}};
    prev = '{12'h000, 12'h000};
    {i_sys_clk, i_rst_n, i_wr_en, i_rd_en, i_chan_sel} = 5'h00;
    {i_reg_sel, i_wdata, i_tmr3_ovf, i_tmr4_ovf, i_tmr2_ovf} = 13'h0000;
    errors  = 0;
    n_tests = 0;
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'h1;
    repeat (3) @(posedge i_sys_clk);
    rd(1'h0, dfc_pkg::DFC_SEL_CTRL, 8'h00);
    rd(1'h1, dfc_pkg::DFC_SEL_CTRL, 8'h00);
    chk({11'h000, o_chan_out[0].drive_en}, 12'h000);
    $display("test reset done");
    // every format across both channels, unused bits written as ones
    foreach (rows[i]) begin
      wr(rows[i].ch, dfc_pkg::DFC_SEL_CTRL, {5'h1C, rows[i].fmt});
      wr(rows[i].ch, dfc_pkg::DFC_SEL_LOW, rows[i].lo);
      pulse(3'h7);
      step();
      chk(o_chan_out[rows[i].ch].code, prev[rows[i].ch]);
      wr(rows[i].ch, dfc_pkg::DFC_SEL_HIGH, rows[i].hi);
      step();
      chk(o_chan_out[rows[i].ch].code, rows[i].code);
      rd(rows[i].ch, dfc_pkg::DFC_SEL_CTRL, {5'h10, rows[i].fmt});
      chk({11'h000, o_chan_out[rows[i].ch].drive_en}, 12'h001);
      prev[rows[i].ch] = rows[i].code;
    end
    $display("test formats done");
    // timer-driven updates on the second channel, first channel left alone
    for (int m = 1; m < 4; m++) begin
      wr(1'h1, dfc_pkg::DFC_SEL_CTRL, {3'h4, m[1:0], 3'h4});
      wr(1'h1, dfc_pkg::DFC_SEL_HIGH, 8'h40 + 8'(m));
      wr(1'h1, dfc_pkg::DFC_SEL_LOW, 8'h90);
      step();
      chk(o_chan_out[1].code, prev[1]);
      pulse(3'h1 << (m % 3));
      step();
      chk(o_chan_out[1].code, prev[1]);
      pulse(3'h1 << (m - 1));
      step();
      prev[1] = {8'h40 + 8'(m), 4'h9};
      chk(o_chan_out[1].code, prev[1]);
      chk(o_chan_out[0].code, prev[0]);
    end
    $display("test timer modes done");
    // unmapped selector and shutdown
    wr(1'h0, 2'h3, 8'hFF);
    rd(1'h0, 2'h3, 8'h00);
    rd(1'h0, dfc_pkg::DFC_SEL_CTRL, 8'h87);
    rd(1'h0, dfc_pkg::DFC_SEL_HIGH, 8'h7B);
    rd(1'h0, dfc_pkg::DFC_SEL_LOW, 8'hE0);
    wr(1'h0, dfc_pkg::DFC_SEL_CTRL, 8'h00);
    step();
    chk({11'h000, o_chan_out[0].drive_en}, 12'h000);
    $display("test unmapped and shutdown done");
    // reset in mid-run
    @(posedge i_sys_clk);
    i_rst_n <= 1'h0;
    step();
    chk(o_chan_out[1].code, 12'h000);
    chk({11'h000, o_chan_out[1].drive_en}, 12'h000);
    @(posedge i_sys_clk);
    i_rst_n <= 1'h1;
    repeat (3) @(posedge i_sys_clk);
    rd(1'h1, dfc_pkg::DFC_SEL_CTRL, 8'h00);
    $display("test mid-run reset done");
    conclude();
  end
endmodule : dfc_top_tb
